// ===== rtl/power_stop_config_regs.sv
// Purpose: Power management status/control and system option registers
// Assumes: Wishbone classic slave, rst is any reset, por_pulse marks power-on
// Notes: Comparator and wake detection are outside; their results arrive as inputs
//
// Behaviour
// - The warning flag sets when the supply is below the warning trip, including right after reset.
// - The warning flag reads one while a warning exists or has occurred and is not cleared.
// - Writing one to the warning acknowledge clears the flag only when the warning is gone.
// - Bit 5 selects the low (0) or high (1) detect trip level.
// - The detect select accepts only its first write after power-on reset.
// - Bit 4 selects the low (0) or high (1) warning trip level.
// - The power down wake flag reads one after waking from partial power down.
// - Writing one to the power down acknowledge clears the wake flag.
// - Bit 0 picks stop mode, retained (0) or partial power down (1), first write only.
// - Options bit 7 picks the watchdog clock, write-once after reset.
// - Options bit 3 picks one shared timer clock (0) or separate timer clocks (1).
`include "power_stop_cfg.svh"
`default_nettype none
module power_stop_config_regs (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic por_pulse,
    input wire logic supply_below_warning,
    input wire logic power_down_wake,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic detect_threshold_select,
    output logic warning_threshold_select,
    output logic stop_mode_select,
    output logic watchdog_clock_select,
    output logic timer_clock_config,
    output logic irq
);
    import power_stop_pkg::*;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    bus_state_type bus_state;
    logic req;
    logic wr_lane0;
    logic wr_pmsc;
    logic wr_opts;
    logic wr_status;
    logic wr_mask;
    logic voltage_warning_flag;
    logic power_down_wake_flag;
    logic warn_sel_reg;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [1:0] irq_events;
    logic stop_sel_q;
    logic wdog_sel_q;
    logic detect_sel_q;
    logic [31:0] next_rdata;

    // Decode of an offset match used by every write strobe
    function automatic logic hit(input logic [3:0] adr, input logic [3:0] offs);
        hit = (adr[3:2] == offs[3:2]);
    endfunction

    assign req = wb_cyc_i && wb_stb_i && (bus_state == BUS_IDLE);
    assign wr_lane0 = req && wb_we_i && wb_sel_i[0];
    assign wr_pmsc = wr_lane0 && hit(wb_adr_i, `PMSC_OFFSET);
    assign wr_opts = wr_lane0 && hit(wb_adr_i, `OPTS_OFFSET);
    assign wr_status = wr_lane0 && hit(wb_adr_i, `IRQ_STATUS_OFFSET);
    assign wr_mask = wr_lane0 && hit(wb_adr_i, `IRQ_MASK_OFFSET);

    // Single-wait ack: answer one cycle after the request, then release
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bus_state <= BUS_IDLE;
            wb_ack_o <= 1'b0;
        end else begin
            case (bus_state)
                BUS_IDLE: begin
                    if (wb_cyc_i && wb_stb_i) begin
                        bus_state <= BUS_ACK;
                        wb_ack_o <= 1'b1;
                    end
                end
                BUS_ACK: begin
                    bus_state <= BUS_IDLE;
                    wb_ack_o <= 1'b0;
                end
                default: begin
                    bus_state <= BUS_IDLE;
                    wb_ack_o <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------
    // Warning flag: set by level, ack honoured only when the warning is gone
    sticky_event_flag warn_flag_inst (
        .core_clk(core_clk),
        .rst(rst),
        .set_event(supply_below_warning),
        .clear_req(wr_pmsc && wb_dat_i[`WARN_ACK_BIT] && !supply_below_warning),
        .flag(voltage_warning_flag)
    );

    // Wake flag: set on wake from partial power down, cleared by ack
    sticky_event_flag pd_flag_inst (
        .core_clk(core_clk),
        .rst(rst),
        .set_event(power_down_wake),
        .clear_req(wr_pmsc && wb_dat_i[`PD_ACK_BIT]),
        .flag(power_down_wake_flag)
    );

    // ------------------------------------------------------------------
    // Configuration bits
    // ------------------------------------------------------------------
    // Detect select: held across non-power-on resets, write-once per POR
    write_once_bit detect_sel_inst (
        .core_clk(core_clk),
        .rst(1'b0),
        .clear_pulse(por_pulse),
        .wr_pulse(wr_pmsc && !rst),
        .wr_value(wb_dat_i[`DETECT_SEL_BIT]),
        .value(detect_sel_q)
    );

    // Warning select: free read/write, cleared only by power-on
    always_ff @(posedge core_clk) begin
        if (por_pulse) begin
            warn_sel_reg <= `BIT_RESET;
        end else if (wr_pmsc && !rst) begin
            warn_sel_reg <= wb_dat_i[`WARN_SEL_BIT];
        end
    end

    // Stop mode select: write-once after any reset
    write_once_bit stop_sel_inst (
        .core_clk(core_clk),
        .rst(rst),
        .clear_pulse(1'b0),
        .wr_pulse(wr_pmsc),
        .wr_value(wb_dat_i[`STOP_SEL_BIT]),
        .value(stop_sel_q)
    );

    // Watchdog clock select: write-once after any reset, resets to slow clock
    write_once_bit wdog_sel_inst (
        .core_clk(core_clk),
        .rst(rst),
        .clear_pulse(1'b0),
        .wr_pulse(wr_opts),
        .wr_value(wb_dat_i[`WDOG_SEL_BIT]),
        .value(wdog_sel_q)
    );

    // Timer clock routing: plain read/write
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            timer_clock_config <= `BIT_RESET;
        end else if (wr_opts) begin
            timer_clock_config <= wb_dat_i[`TIMER_CFG_BIT];
        end
    end

    // Registered copies of configuration outputs
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stop_mode_select <= 1'b0;
            watchdog_clock_select <= 1'b0;
        end else begin
            stop_mode_select <= stop_sel_q;
            watchdog_clock_select <= wdog_sel_q;
        end
    end

    // Threshold outputs follow their registers outside reset handling
    always_ff @(posedge core_clk) begin
        if (por_pulse) begin
            detect_threshold_select <= 1'b0;
            warning_threshold_select <= 1'b0;
        end else begin
            detect_threshold_select <= detect_sel_q;
            warning_threshold_select <= warn_sel_reg;
        end
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    // Rising edges of the two flags are events; write one to clear
    logic warn_flag_d;
    logic pd_flag_d;
    assign irq_events = {power_down_wake_flag && !pd_flag_d,
                         voltage_warning_flag && !warn_flag_d};

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            warn_flag_d <= 1'b0;
            pd_flag_d <= 1'b0;
            irq_status <= `IRQ_RESET;
            irq_mask <= `IRQ_RESET;
            irq <= 1'b0;
        end else begin
            warn_flag_d <= voltage_warning_flag;
            pd_flag_d <= power_down_wake_flag;
            irq_status <= irq_events | (irq_status & ~(wr_status ? wb_dat_i[1:0] : 2'h0));
            if (wr_mask) begin
                irq_mask <= wb_dat_i[1:0];
            end
            irq <= |(irq_status & irq_mask);
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_comb begin
        next_rdata = 32'h0;
        if (hit(wb_adr_i, `PMSC_OFFSET)) begin
            next_rdata[`WARN_FLAG_BIT] = voltage_warning_flag;
            next_rdata[`DETECT_SEL_BIT] = detect_sel_q;
            next_rdata[`WARN_SEL_BIT] = warn_sel_reg;
            next_rdata[`PD_FLAG_BIT] = power_down_wake_flag;
            next_rdata[`STOP_SEL_BIT] = stop_sel_q;
        end else if (hit(wb_adr_i, `OPTS_OFFSET)) begin
            next_rdata[`WDOG_SEL_BIT] = wdog_sel_q;
            next_rdata[`TIMER_CFG_BIT] = timer_clock_config;
        end else if (hit(wb_adr_i, `IRQ_STATUS_OFFSET)) begin
            next_rdata[1:0] = irq_status;
        end else begin
            next_rdata[1:0] = irq_mask;
        end
    end

    // Capture read data with the ack
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wb_dat_o <= 32'h0;
        end else if (req) begin
            wb_dat_o <= next_rdata;
        end
    end
endmodule
`default_nettype wire

// ===== rtl/power_stop_cfg.svh
// Purpose: Constants for the power and stop configuration register bank
// Assumes: Word-aligned Wishbone byte addresses
// Notes: Offsets are local to the bank
`ifndef POWER_STOP_CFG_SVH
`define POWER_STOP_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define PMSC_OFFSET 4'h0
`define OPTS_OFFSET 4'h4
`define IRQ_STATUS_OFFSET 4'h8
`define IRQ_MASK_OFFSET 4'hC

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define WARN_FLAG_BIT 7
`define WARN_ACK_BIT 6
`define DETECT_SEL_BIT 5
`define WARN_SEL_BIT 4
`define PD_FLAG_BIT 3
`define PD_ACK_BIT 2
`define STOP_SEL_BIT 0
`define WDOG_SEL_BIT 7
`define TIMER_CFG_BIT 3
`define IRQ_WARN_BIT 0
`define IRQ_PD_BIT 1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define BIT_RESET 1'b0
`define IRQ_RESET 2'h0

`endif

// ===== rtl/power_stop_pkg.sv
// Purpose: Types shared by the power and stop configuration bank
// Assumes: Nothing beyond the header constants
// Notes: Bus access states
`default_nettype none
package power_stop_pkg;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bus_state_type;
    typedef logic [7:0] byte_type;
endpackage
`default_nettype wire

// ===== rtl/write_once_bit.sv
// Purpose: One configuration bit that accepts only its first write
// Assumes: wr_pulse is a single-cycle strobe
// Notes: clear_pulse restarts the window and zeroes the bit
`include "power_stop_cfg.svh"
`default_nettype none
module write_once_bit (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clear_pulse,
    input wire logic wr_pulse,
    input wire logic wr_value,
    output logic value
);
    logic written;

    // Latch value and lock on first write
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            value <= `BIT_RESET;
            written <= 1'b0;
        end else if (clear_pulse) begin
            value <= `BIT_RESET;
            written <= 1'b0;
        end else if (wr_pulse && !written) begin
            value <= wr_value;
            written <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ===== rtl/sticky_event_flag.sv
// Purpose: Sticky flag set by an event, cleared by an acknowledge
// Assumes: Set wins over clear in the same cycle
// Notes: Clear may be gated by the caller
`default_nettype none
module sticky_event_flag (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic set_event,
    input wire logic clear_req,
    output logic flag
);
    // Set has priority over clear
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flag <= 1'b0;
        end else if (set_event) begin
            flag <= 1'b1;
        end else if (clear_req) begin
            flag <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== testbench/power_stop_checker.sv
// Purpose: Port-level checks for the power and stop register bank
// Assumes: One clock, rst asynchronous and active high
// Notes: Select outputs trail their register content by one cycle; timer_clock_config is the register itself
`default_nettype none
module power_stop_checker (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic supply_below_warning,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic detect_threshold_select,
    input wire logic stop_mode_select,
    input wire logic watchdog_clock_select,
    input wire logic timer_clock_config,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic rd0, wr4;
    // Completed read of the power register, completed write of options
    assign rd0 = wb_ack_o && !wb_we_i && wb_adr_i == 4'h0;
    assign wr4 = wb_ack_o && wb_we_i && wb_adr_i == 4'h4;
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_after_take: assert property ($rose(wb_stb_i) && wb_cyc_i |=> wb_ack_o)
        else $error("no ack one cycle after request");
    a_warn_flag_read: assert property (supply_below_warning [*4] ##0 rd0 |-> wb_dat_o[7])
        else $error("warning flag clear while supply low");
    a_ack_bits_zero: assert property (rd0 |-> !wb_dat_o[6] && !wb_dat_o[2])
        else $error("acknowledge bit read as one");
    a_detect_locked: assert property ($rose(detect_threshold_select) |=>
        detect_threshold_select [*8])
        else $error("detect select changed after first write");
    a_stop_locked: assert property ($rose(stop_mode_select) |=> stop_mode_select [*8])
        else $error("stop select changed after first write");
    a_wdog_locked: assert property ($rose(watchdog_clock_select) |=>
        watchdog_clock_select [*8])
        else $error("watchdog select changed after first write");
    a_timer_cause: assert property ($changed(timer_clock_config) |-> wr4 || $past(wr4))
        else $error("timer config changed without a write");
    a_reset_clears: assert property ($fell(rst) |-> !stop_mode_select &&
        !watchdog_clock_select && !timer_clock_config && !irq)
        else $error("outputs not cleared by reset");
    c_warn_read: cover property (supply_below_warning [*4] ##0 rd0);
    c_stop_set: cover property ($rose(stop_mode_select));
    c_irq_high: cover property ($rose(irq));
endmodule
`default_nettype wire

// ===== testbench/power_stop_config_regs_tb.sv
// Purpose: Self-checking bench for the power and stop register bank
// Assumes: Wishbone classic, byte lane 0 carries each register
// Notes: Random writes come from a fixed-seed xorshift
`default_nettype none
module power_stop_config_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, rst = 1'b1, por_pulse = 1'b1, supply_below_warning = 1'b0;
    logic power_down_wake = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, r;
    logic [31:0] seed = 32'hE81D20B8;
    logic wb_ack_o, detect_threshold_select, warning_threshold_select, stop_mode_select;
    logic watchdog_clock_select, timer_clock_config, irq;
    int n_mismatch = 0, tests_run = 0;
    // 100 MHz clock
    always #5 core_clk = ~core_clk;
    power_stop_config_regs DUT (.core_clk(core_clk), .rst(rst), .por_pulse(por_pulse),
        .supply_below_warning(supply_below_warning), .power_down_wake(power_down_wake),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .detect_threshold_select(detect_threshold_select),
        .warning_threshold_select(warning_threshold_select),
        .stop_mode_select(stop_mode_select), .watchdog_clock_select(watchdog_clock_select),
        .timer_clock_config(timer_clock_config), .irq(irq));
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic conclude();
        $display("compares %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One classic cycle; read data taken at the ack edge
    task automatic bus(input logic we, input logic [3:0] a, input logic [7:0] d);
        int i;
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        wb_sel_i <= 4'h1;
        for (i = 0; i < 20; i++) begin
            @(posedge core_clk);
            if (wb_ack_o === 1'b1) break;
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (i == 20) begin
            n_mismatch++;
            conclude();
        end
    endtask
    task automatic rdchk(input string nm, input logic [3:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(nm, rd, {24'h0, e});
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic rs(input logic p);
        @(posedge core_clk);
        rst <= 1'b1;
        por_pulse <= p;
        wt(5);
        rst <= 1'b0;
        por_pulse <= 1'b0;
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rs(1'b1);
        rdchk("pm", 4'h0, 8'h00);
        rdchk("opt", 4'h4, 8'h00);
        bus(1'b1, 4'h0, 8'h31);
        bus(1'b1, 4'h0, 8'h00);
        rdchk("pm", 4'h0, 8'h21);
        wt(3);
        chk("dsel", detect_threshold_select, 1);
        chk("stop", stop_mode_select, 1);
        bus(1'b1, 4'h4, 8'h80);
        for (int k = 0; k < 6; k++) begin
            r = xs();
            bus(1'b1, 4'h0, r[7:0] & 8'hBB);
            rdchk("pm", 4'h0, 8'h21 | (r[7:0] & 8'h10));
            bus(1'b1, 4'h4, r[15:8] & 8'h7F);
            rdchk("opt", 4'h4, 8'h80 | (r[15:8] & 8'h08));
            wt(3);
            chk("tmr", timer_clock_config, r[11]);
            chk("wsel", warning_threshold_select, r[4]);
        end
        chk("wdog", watchdog_clock_select, 1);
        bus(1'b1, 4'h0, 8'h10);
        supply_below_warning <= 1'b1;
        wt(4);
        rdchk("pm", 4'h0, 8'hB1);
        bus(1'b1, 4'h0, 8'h50);
        rdchk("pm", 4'h0, 8'hB1);
        supply_below_warning <= 1'b0;
        wt(2);
        rdchk("pm", 4'h0, 8'hB1);
        bus(1'b1, 4'h0, 8'h50);
        rdchk("pm", 4'h0, 8'h31);
        power_down_wake <= 1'b1;
        wt(1);
        power_down_wake <= 1'b0;
        rdchk("pm", 4'h0, 8'h39);
        bus(1'b1, 4'h0, 8'h10);
        rdchk("pm", 4'h0, 8'h39);
        bus(1'b1, 4'h0, 8'h14);
        rdchk("pm", 4'h0, 8'h31);
        // Interrupt status, mask and clear
        rdchk("ist", 4'h8, 8'h03);
        chk("irq", irq, 0);
        bus(1'b1, 4'hC, 8'h01);
        wt(2);
        chk("irq", irq, 1);
        bus(1'b1, 4'h8, 8'h01);
        wt(2);
        chk("irq", irq, 0);
        rdchk("ist", 4'h8, 8'h02);
        bus(1'b1, 4'hC, 8'h03);
        rdchk("imsk", 4'hC, 8'h03);
        wt(2);
        chk("irq", irq, 1);
        bus(1'b1, 4'h8, 8'h02);
        wt(2);
        chk("irq", irq, 0);
        bus(1'b0, 4'h2, 8'h00);
        // Plain reset keeps the threshold selects, power-on clears them
        rs(1'b0);
        rdchk("pm", 4'h0, 8'h30);
        rdchk("opt", 4'h4, 8'h00);
        // Warning select is plain read/write, so this write also clears it
        bus(1'b1, 4'h0, 8'h01);
        rdchk("pm", 4'h0, 8'h21);
        supply_below_warning <= 1'b1;
        rs(1'b1);
        wt(3);
        rdchk("pm", 4'h0, 8'h80);
        conclude();
    end
endmodule
bind power_stop_config_regs power_stop_checker chk_i (.core_clk(core_clk), .rst(rst),
    .supply_below_warning(supply_below_warning), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .detect_threshold_select(detect_threshold_select), .stop_mode_select(stop_mode_select),
    .watchdog_clock_select(watchdog_clock_select), .timer_clock_config(timer_clock_config),
    .irq(irq));
`default_nettype wire
